// ---- hdl/ufbc_core.sv ----
// ufbc_core: usart framing, buffer flags, buffer interrupts and the
// prescaler/divisor baud chain behind a classic wishbone slave.
// assumes serial pins are asynchronous to i_ref_clk.
`timescale 1ns/1ps

// Overview of operation
// R1: sync mode: launch rising, capture falling edge
// R2: sync mode clock equals bit rate
// R3: external clock or driven internal clock shifts
// R4: code 01: seven data bits framing
// R5: code 00: eight data bits framing
// R6: nine-bit: eighth bits buffers, ninth separate
// R7: no parity in nine-bit format
// R8: parity only 7/8 bit, type by selects
// R9: shared bit: ninth bit or parity select
// R10: receiver needs only one stop bit
// R11: software matches transmit and receive framing
// R12: two interrupt vectors at 0xec to 0xef
// R13: tx interrupt while empty and enabled
// R14: rx interrupt while full and enabled
// R15: tx and rx clocks independently selectable
// R16: prescaler half steps then 11-bit divisor
// R17: divisor high bits in prescaler register, reset
// R18: select zero stops the usart clock
// R19: prescaler code k divides by (k+1)/2
// R20: async: sixteen ticks per bit
// R21: sync: two ticks per bit
// R22: divisor counts programmed value plus one
// R23: tx empty set on load, cleared on write
// R24: rx full set on copy, cleared on read
// R25: async mode clock sixteen times bit rate
// R26: divisor reloads, one pulse per reload
// R27: half steps by alternating divide lengths
module ufbc_core
	import ufbc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_sel,
	input wire logic [4:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_rx_pin,
	output logic o_tx_pin,
	input wire logic i_serial_clock_pin,
	output logic o_serial_clock_pin,
	output logic o_serial_clock_pin_oe_n,
	input wire logic i_clk_pin_is_output,
	output logic o_tx_irq,
	output logic o_rx_irq
);

	// ***************************************************************
	// register state
	// ***************************************************************
	ufbc_wb_req_t req;
	logic [7:0] main_ctrl_reg, irq_clock_ctrl_reg, rx_status_reg;
	logic [7:0] prescaler_select_reg, baud_reg;
	logic [7:0] tx_holding_buffer, rx_holding_buffer;
	logic ack, next_ack;
	logic [31:0] rdat, next_rdat;
	logic [7:0] next_main, next_ic, next_rs, next_psr, next_baud, next_txb;
	logic [7:0] next_rxb;
	ufbc_frame_t fr;
	logic wr_txb, rd_rxb, rd_rs, acc;

	assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we,
		sel: i_wb_sel, adr: i_wb_adr, dat: i_wb_dat};
	assign acc = req.cyc && req.stb && !ack && req.sel[0];
	assign wr_txb = acc && req.we && req.adr == UFBC_OFF_TXBUF;
	assign rd_rxb = acc && !req.we && req.adr == UFBC_OFF_RXBUF;
	assign rd_rs = acc && !req.we && req.adr == UFBC_OFF_RXST;
	assign fr = '{parity_enable: main_ctrl_reg[UFBC_MC_PEN],
		parity_select_hi: main_ctrl_reg[UFBC_MC_PSEL_HI],
		parity_select_lo: main_ctrl_reg[UFBC_MC_PSEL_LO],
		char_len_code_b1: main_ctrl_reg[UFBC_MC_CHAR_LEN_CODE_B1],
		char_len_code_b0: main_ctrl_reg[UFBC_MC_CHAR_LEN_CODE_B0],
		stop2: irq_clock_ctrl_reg[UFBC_IC_STOP2],
		sync_mode: irq_clock_ctrl_reg[UFBC_IC_SYNC]};

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	logic [1:0] rx_sy, ck_sy;
	logic ck_d;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rx_sy <= 2'h3;
			ck_sy <= 2'h0;
			ck_d <= 1'b0;
		end else begin
			rx_sy <= {rx_sy[0], i_rx_pin};
			ck_sy <= {ck_sy[0], i_serial_clock_pin};
			ck_d <= ck_sy[1];
		end
	end
	wire rxd = rx_sy[1];

	// ***************************************************************
	// baud chain
	// ***************************************************************
	logic [4:0] pre_cnt, next_pre_cnt;
	logic pre_half, next_pre_half, pre_tick;
	logic [10:0] div_cnt, next_div_cnt;
	logic baud_tick, int_clk, next_int_clk;
	logic [4:0] sel_code;
	logic [10:0] div_val;
	logic [4:0] pre_len;
	assign sel_code = prescaler_select_reg[7:3];
	assign div_val = {prescaler_select_reg[2:0], baud_reg}; // R17
	// code k gives k+1 half cycles; odd totals alternate k/2 and k/2+1
	always_comb begin
		pre_len = {1'b0, sel_code[4:1]} + {4'h0, sel_code[0] | pre_half}; // R27
		if (pre_len == 5'h00) begin
			pre_len = 5'h01;
		end
	end
	always_comb begin
		next_pre_cnt = pre_cnt;
		next_pre_half = pre_half;
		next_div_cnt = div_cnt;
		pre_tick = 1'b0;
		baud_tick = 1'b0;
		if (sel_code == UFBC_PRE_OFF) begin // R18
			next_pre_cnt = 5'h00;
			next_pre_half = 1'b0;
			next_div_cnt = div_val;
		end else begin
			if (pre_cnt + 5'h01 >= pre_len) begin // R19
				next_pre_cnt = 5'h00;
				pre_tick = 1'b1;
				if (!sel_code[0]) begin
					next_pre_half = !pre_half; // R27
				end
			end else begin
				next_pre_cnt = pre_cnt + 5'h01;
			end
			if (pre_tick) begin // R16
				if (div_cnt == 11'h000) begin
					next_div_cnt = div_val; // R22
					baud_tick = 1'b1; // R26
				end else begin
					next_div_cnt = div_cnt - 11'h001;
				end
			end
		end
	end
	// in sync mode the driven serial clock toggles once per baud tick: two per bit; it holds in async mode
	assign next_int_clk = (fr.sync_mode && baud_tick) ? !int_clk : int_clk;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pre_cnt <= 5'h00;
			pre_half <= 1'b0;
			div_cnt <= 11'h000;
			int_clk <= 1'b0;
		end else begin
			pre_cnt <= next_pre_cnt;
			pre_half <= next_pre_half;
			div_cnt <= next_div_cnt;
			int_clk <= next_int_clk;
		end
	end

	// ***************************************************************
	// shift timing per section
	// ***************************************************************
	function automatic logic [1:0] ufbc_clk_ev(input logic ext, input logic sy,
			input logic bt, input logic ic, input logic cr, input logic cf);
		logic [1:0] ev;
		ev = 2'b00;
		if (sy) begin // R21
			if (ext && !i_clk_pin_is_output) begin
				ev = {cr, cf}; // R3
			end else if (bt) begin
				ev = {!ic, ic};
			end
		end else begin
			ev = {bt && !ext, 1'b0}; // R25
			if (ext) begin
				ev = {cr, 1'b0};
			end
		end
		return ev;
	endfunction
	logic [1:0] tx_ev, rx_ev;
	wire ck_rise = ck_sy[1] && !ck_d;
	wire ck_fall = !ck_sy[1] && ck_d;
	assign tx_ev = ufbc_clk_ev(irq_clock_ctrl_reg[UFBC_IC_TXEXT], // R15
		fr.sync_mode, baud_tick, int_clk, ck_rise, ck_fall);
	assign rx_ev = ufbc_clk_ev(irq_clock_ctrl_reg[UFBC_IC_RXEXT], // R15
		fr.sync_mode, baud_tick, int_clk, ck_rise, ck_fall);
	// async: 16 ticks per bit; sync: rising launches, falling captures
	wire [4:0] ovs = fr.sync_mode ? UFBC_OVS_SYNC : UFBC_OVS_ASYNC; // R2

	// ***************************************************************
	// frame layout
	// ***************************************************************
	wire nine = fr.char_len_code_b1 && !fr.char_len_code_b0;
	wire par_on = fr.parity_enable && !nine; // R7 R8
	wire [3:0] nbits = nine ? 4'h9 : (fr.char_len_code_b0 ? 4'h7 : 4'h8); // R4 R5
	function automatic logic ufbc_par(input logic [8:0] d, input logic [3:0] n,
			input logic hi, input logic lo);
		logic p;
		p = ^(d[7:0] & (n == 4'h7 ? 8'h7f : 8'hff));
		case ({hi, lo}) // R9
			2'b00: p = !p;
			2'b01: p = p;
			2'b10: p = 1'b1;
			default: p = 1'b0;
		endcase
		return p;
	endfunction

	// ***************************************************************
	// transmitter
	// ***************************************************************
	logic [10:0] tx_sh, next_tx_sh;
	logic [3:0] tx_left, next_tx_left;
	logic [4:0] tx_sub, next_tx_sub;
	logic tx_busy, next_tx_busy, tx_out, next_tx_out, tx_load;
	logic [3:0] tx_total;
	assign tx_total = nbits + {3'h0, par_on} + 4'h1 + {3'h0, fr.stop2};
	always_comb begin
		next_tx_sh = tx_sh;
		next_tx_left = tx_left;
		next_tx_sub = tx_sub;
		next_tx_busy = tx_busy;
		next_tx_out = tx_out;
		tx_load = 1'b0;
		if (tx_ev[1]) begin // R1
			if (tx_sub != 5'h00) begin
				next_tx_sub = tx_sub - 5'h01;
			end else if (tx_busy && tx_left != 4'h0) begin
				next_tx_out = tx_sh[0];
				next_tx_sh = {1'b1, tx_sh[10:1]};
				next_tx_left = tx_left - 4'h1;
				next_tx_sub = ovs;
			end else if (!main_ctrl_reg[UFBC_MC_TXEMPTY]) begin
				tx_load = 1'b1; // R23
				next_tx_busy = 1'b1;
				next_tx_out = 1'b0;
				next_tx_sh = {3'b111, tx_holding_buffer};
				if (nine) begin
					next_tx_sh[8] = fr.parity_select_lo; // R6 R9
				end else if (par_on) begin
					next_tx_sh[nbits] = ufbc_par({1'b0, tx_holding_buffer},
						nbits, fr.parity_select_hi, fr.parity_select_lo);
				end
				if (nbits == 4'h7) begin
					next_tx_sh[7] = par_on ? next_tx_sh[7] : 1'b1;
				end
				next_tx_left = tx_total;
				next_tx_sub = ovs;
			end else begin
				next_tx_busy = 1'b0;
				next_tx_out = 1'b1;
			end
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			tx_sh <= 11'h7ff;
			tx_left <= 4'h0;
			tx_sub <= 5'h00;
			tx_busy <= 1'b0;
			tx_out <= 1'b1;
		end else begin
			tx_sh <= next_tx_sh;
			tx_left <= next_tx_left;
			tx_sub <= next_tx_sub;
			tx_busy <= next_tx_busy;
			tx_out <= next_tx_out;
		end
	end

	// ***************************************************************
	// receiver
	// ***************************************************************
	logic [9:0] rx_sh, next_rx_sh;
	logic [3:0] rx_left, next_rx_left;
	logic [4:0] rx_sub, next_rx_sub;
	logic rx_busy, next_rx_busy, rx_done, rx_fe, rx_pe;
	logic [3:0] rx_data_bits;
	assign rx_data_bits = nbits + {3'h0, par_on};
	wire rx_smp = fr.sync_mode ? rx_ev[0] : rx_ev[1]; // R1
	always_comb begin
		next_rx_sh = rx_sh;
		next_rx_left = rx_left;
		next_rx_sub = rx_sub;
		next_rx_busy = rx_busy;
		rx_done = 1'b0;
		rx_fe = 1'b0;
		rx_pe = 1'b0;
		if (rx_smp) begin
			if (!rx_busy) begin
				if (!rxd) begin
					next_rx_busy = 1'b1;
					next_rx_left = rx_data_bits + 4'h1;
					next_rx_sub = fr.sync_mode ? 5'h00 : {1'b0, UFBC_RX_MID} + ovs;
				end
			end else if (rx_sub != 5'h00) begin
				next_rx_sub = rx_sub - 5'h01;
			end else if (rx_left != 4'h1) begin
				next_rx_sh = {rxd, rx_sh[9:1]};
				next_rx_left = rx_left - 4'h1;
				next_rx_sub = fr.sync_mode ? 5'h00 : ovs;
			end else begin
				// one stop bit closes the frame
				next_rx_busy = 1'b0; // R10
				rx_done = 1'b1;
				rx_fe = !rxd;
				next_rx_sh = rx_sh >> (4'ha - rx_data_bits);
				rx_pe = par_on && (next_rx_sh[nbits] != ufbc_par(
					next_rx_sh[8:0], nbits, fr.parity_select_hi,
					fr.parity_select_lo));
			end
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rx_sh <= 10'h000;
			rx_left <= 4'h0;
			rx_sub <= 5'h00;
			rx_busy <= 1'b0;
		end else begin
			rx_sh <= next_rx_sh;
			rx_left <= next_rx_left;
			rx_sub <= next_rx_sub;
			rx_busy <= next_rx_busy;
		end
	end

	// ***************************************************************
	// wishbone slave and register updates
	// ***************************************************************
	always_comb begin
		next_main = main_ctrl_reg;
		next_ic = irq_clock_ctrl_reg;
		next_rs = rx_status_reg;
		next_psr = prescaler_select_reg;
		next_baud = baud_reg;
		next_txb = tx_holding_buffer;
		next_rxb = rx_holding_buffer;
		next_ack = acc;
		next_rdat = 32'h0;
		if (acc && !req.we) begin
			unique case (req.adr)
				UFBC_OFF_TXBUF: next_rdat = {24'h0, tx_holding_buffer};
				UFBC_OFF_RXBUF: next_rdat = {24'h0, rx_holding_buffer};
				UFBC_OFF_MAIN: next_rdat = {24'h0, main_ctrl_reg};
				UFBC_OFF_RXST: next_rdat = {24'h0, rx_status_reg};
				UFBC_OFF_IRQCK: next_rdat = {24'h0, irq_clock_ctrl_reg};
				UFBC_OFF_BAUD: next_rdat = {24'h0, baud_reg};
				UFBC_OFF_PSR: next_rdat = {24'h0, prescaler_select_reg};
				default: next_rdat = 32'h0;
			endcase
		end
		if (rd_rs) begin
			next_rs[7:5] = 3'h0;
		end
		if (acc && req.we) begin
			unique case (req.adr)
				UFBC_OFF_TXBUF: next_txb = req.dat[7:0];
				UFBC_OFF_MAIN: next_main = (req.dat[7:0] & UFBC_MC_RW_MASK)
					| (main_ctrl_reg & ~UFBC_MC_RW_MASK);
				UFBC_OFF_IRQCK: next_ic = req.dat[7:0];
				UFBC_OFF_BAUD: next_baud = req.dat[7:0];
				UFBC_OFF_PSR: next_psr = req.dat[7:0];
				default: next_rs = next_rs;
			endcase
		end
		if (wr_txb) begin
			next_main[UFBC_MC_TXEMPTY] = 1'b0; // R23
		end
		if (tx_load) begin
			next_main[UFBC_MC_TXEMPTY] = 1'b1; // R23
		end
		if (rd_rxb) begin
			next_main[UFBC_MC_RXFULL] = 1'b0; // R24
		end
		if (rx_done) begin
			if (main_ctrl_reg[UFBC_MC_RXFULL] && !rd_rxb) begin
				next_rs[UFBC_RS_OVR] = 1'b1;
			end
			next_rxb = next_rx_sh[7:0];
			next_rs[UFBC_RS_RX9] = nine & next_rx_sh[8]; // R6
			next_rs[UFBC_RS_FERR] = next_rs[UFBC_RS_FERR] | rx_fe;
			next_rs[UFBC_RS_PERR] = next_rs[UFBC_RS_PERR] | rx_pe;
			next_main[UFBC_MC_RXFULL] = 1'b1; // R24
		end
		next_rs[UFBC_RS_TXGO] = next_tx_busy;
		next_rs[UFBC_RS_RXGO] = next_rx_busy;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			main_ctrl_reg <= UFBC_MC_RESET;
			irq_clock_ctrl_reg <= UFBC_IC_RESET;
			rx_status_reg <= 8'h00;
			prescaler_select_reg <= UFBC_PSR_RESET; // R17
			baud_reg <= UFBC_BAUD_RESET;
			tx_holding_buffer <= 8'h00;
			rx_holding_buffer <= 8'h00;
			ack <= 1'b0;
			rdat <= 32'h0;
		end else begin
			main_ctrl_reg <= next_main;
			irq_clock_ctrl_reg <= next_ic;
			rx_status_reg <= next_rs;
			prescaler_select_reg <= next_psr;
			baud_reg <= next_baud;
			tx_holding_buffer <= next_txb;
			rx_holding_buffer <= next_rxb;
			ack <= next_ack;
			rdat <= next_rdat;
		end
	end

	assign o_wb_ack = ack;
	assign o_wb_dat = rdat;
	assign o_tx_pin = tx_out;
	assign o_serial_clock_pin = int_clk; // R3
	assign o_serial_clock_pin_oe_n = !i_clk_pin_is_output;
	// level requests toward the vectored controller
	assign o_tx_irq = main_ctrl_reg[UFBC_MC_TXEMPTY] &&
		irq_clock_ctrl_reg[UFBC_IC_TXIE]; // R12 R13
	assign o_rx_irq = main_ctrl_reg[UFBC_MC_RXFULL] &&
		irq_clock_ctrl_reg[UFBC_IC_RXIE]; // R12 R14

	// ***************************************************************
	// checks
	// ***************************************************************
	a_tx_irq_level: assert property ( // R13
		@(posedge i_ref_clk) disable iff (i_rst)
		o_tx_irq == (main_ctrl_reg[0] && irq_clock_ctrl_reg[0]))
		else $error("tx irq mismatch");
	a_rx_irq_clear: assert property ( // R24
		@(posedge i_ref_clk) disable iff (i_rst)
		rd_rxb && !rx_done |=> !main_ctrl_reg[UFBC_MC_RXFULL])
		else $error("rx full not cleared by read");
	a_txe_write_clr: assert property ( // R23
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_txb && !tx_load |=> !main_ctrl_reg[UFBC_MC_TXEMPTY])
		else $error("tx empty not cleared by write");
	a_stop_clock: assert property ( // R18
		@(posedge i_ref_clk) disable iff (i_rst)
		sel_code == 5'h00 |-> !baud_tick)
		else $error("baud tick while stopped");
	a_div_reload: assert property ( // R26
		@(posedge i_ref_clk) disable iff (i_rst)
		baud_tick && sel_code == $past(sel_code) |=>
		div_cnt == $past(div_val))
		else $error("divisor did not reload");
	a_pre_unity: assert property ( // R19
		@(posedge i_ref_clk) disable iff (i_rst)
		sel_code == 5'h01 && $past(sel_code) == 5'h01 |-> pre_tick)
		else $error("factor one must tick every cycle");
	a_nine_no_par: assert property ( // R7
		@(posedge i_ref_clk) disable iff (i_rst)
		nine |-> !par_on)
		else $error("parity active in nine-bit format");
	a_rx_full_set: assert property ( // R24
		@(posedge i_ref_clk) disable iff (i_rst)
		rx_done |=> main_ctrl_reg[UFBC_MC_RXFULL])
		else $error("rx full not set on frame end");
endmodule

// ---- hdl/ufbc_pkg.sv ----
// ufbc_pkg: register map, field positions, reset values and carrier types
// for the usart framing and baud core; assumes a 32-bit classic wishbone.
package ufbc_pkg;

	// ***************************************************************
	// register byte offsets
	// ***************************************************************
	localparam logic [4:0] UFBC_OFF_TXBUF = 5'h00;
	localparam logic [4:0] UFBC_OFF_RXBUF = 5'h04;
	localparam logic [4:0] UFBC_OFF_MAIN = 5'h08;
	localparam logic [4:0] UFBC_OFF_RXST = 5'h0c;
	localparam logic [4:0] UFBC_OFF_IRQCK = 5'h10;
	localparam logic [4:0] UFBC_OFF_BAUD = 5'h14;
	localparam logic [4:0] UFBC_OFF_PSR = 5'h18;

	// ***************************************************************
	// main_ctrl_reg fields
	// ***************************************************************
	localparam int UFBC_MC_TXEMPTY = 0;
	localparam int UFBC_MC_RXFULL = 1;
	localparam int UFBC_MC_CHAR_LEN_CODE_B0 = 3;
	localparam int UFBC_MC_CHAR_LEN_CODE_B1 = 4;
	localparam int UFBC_MC_PSEL_LO = 5;
	localparam int UFBC_MC_PSEL_HI = 6;
	localparam int UFBC_MC_PEN = 7;
	localparam logic [7:0] UFBC_MC_RESET = 8'h01;
	localparam logic [7:0] UFBC_MC_RW_MASK = 8'hf8;

	// ***************************************************************
	// rx_status_reg and irq_clock_ctrl_reg fields
	// ***************************************************************
	localparam int UFBC_RS_RXGO = 0;
	localparam int UFBC_RS_TXGO = 1;
	localparam int UFBC_RS_RX9 = 3;
	localparam int UFBC_RS_PERR = 5;
	localparam int UFBC_RS_FERR = 6;
	localparam int UFBC_RS_OVR = 7;
	localparam int UFBC_IC_TXIE = 0;
	localparam int UFBC_IC_RXIE = 1;
	localparam int UFBC_IC_TXEXT = 2;
	localparam int UFBC_IC_RXEXT = 3;
	localparam int UFBC_IC_SYNC = 4;
	localparam int UFBC_IC_STOP2 = 7;
	localparam logic [7:0] UFBC_IC_RESET = 8'h00;
	localparam logic [7:0] UFBC_PSR_RESET = 8'h00;
	localparam logic [7:0] UFBC_BAUD_RESET = 8'h00;

	// ***************************************************************
	// baud chain constants
	// ***************************************************************
	localparam int UFBC_DIV_W = 11;
	localparam logic [4:0] UFBC_PRE_OFF = 5'h00;
	localparam logic [4:0] UFBC_OVS_ASYNC = 5'h0f;
	localparam logic [4:0] UFBC_OVS_SYNC = 5'h00;
	localparam logic [3:0] UFBC_RX_MID = 4'h7;
	localparam real UFBC_CLK_MHZ = 200.0;

	typedef struct packed {
		logic parity_enable;
		logic parity_select_hi;
		logic parity_select_lo;
		logic char_len_code_b1;
		logic char_len_code_b0;
		logic stop2;
		logic sync_mode;
	} ufbc_frame_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [4:0] adr;
		logic [31:0] dat;
	} ufbc_wb_req_t;

endpackage

// ---- verification/ufbc_far_end.sv ----
// ufbc_far_end: remote serial transceiver facing the core's data pins
// assumes the bench gives every bit time in i_ref_clk cycles
`timescale 1ns/1ps
module ufbc_far_end (
	input wire logic i_ref_clk,
	input wire logic i_line_in,
	input wire logic i_sclk,
	output logic o_line_out
);
	initial o_line_out = 1'b1;

	// ***************************************************************
	// send: start, nb data bits lsb first, then a single stop bit
	// ***************************************************************
	task automatic send(input int bc, input int nb, input logic [9:0] d);
		o_line_out <= 1'b0;
		repeat (bc) @(posedge i_ref_clk);
		for (int i = 0; i < nb; i++) begin
			o_line_out <= d[i];
			repeat (bc) @(posedge i_ref_clk);
		end
		o_line_out <= 1'b1;
		repeat (bc) @(posedge i_ref_clk);
	endtask

	// ***************************************************************
	// recv: samples mid-bit, ok low on missing start or stop
	// ***************************************************************
	task automatic recv(input int bc, input int nb, output logic [9:0] d,
		output logic ok);
		int n;
		d = '0;
		n = 0;
		while (i_line_in !== 1'b0 && n < 20000) begin
			@(posedge i_ref_clk);
			n++;
		end
		repeat (bc / 2) @(posedge i_ref_clk);
		ok = (n < 20000) && (i_line_in === 1'b0);
		for (int i = 0; i < nb; i++) begin
			repeat (bc) @(posedge i_ref_clk);
			d[i] = i_line_in;
		end
		repeat (bc) @(posedge i_ref_clk);
		ok = ok && (i_line_in === 1'b1);
	endtask

	// ***************************************************************
	// sync receive: line read at each falling serial clock edge
	// ***************************************************************
	task automatic fall(output logic b);
		int n;
		n = 0;
		while (i_sclk !== 1'b1 && n < 100) begin
			@(posedge i_ref_clk);
			n++;
		end
		while (i_sclk !== 1'b0 && n < 100) begin
			@(posedge i_ref_clk);
			n++;
		end
		b = i_line_in;
	endtask
	task automatic recv_sync(input int nb, output logic [9:0] d,
		output logic ok);
		logic b;
		int n;
		d = '0;
		b = 1'b1;
		n = 0;
		while (b !== 1'b0 && n < 200) begin
			fall(b);
			n++;
		end
		for (int i = 0; i < nb; i++) begin
			fall(b);
			d[i] = b;
		end
		fall(b);
		ok = (n < 200) && (b === 1'b1);
	endtask
endmodule

// ---- verification/usart_frame_baud_core_test.sv ----
// usart_frame_baud_core_test: self-checking bench for ufbc_core
// assumes ufbc_far_end drives and watches the serial data pins
`timescale 1ns/1ps
module usart_frame_baud_core_test import ufbc_pkg::*;;
	logic i_ref_clk, i_rst, cko, ck_oe_n, rx_line, tx_line, txi, rxi;
	logic ack, ok, ck_is_out;
	logic [31:0] rdat;
	logic [9:0] rd, fd;
	ufbc_wb_req_t req;
	int bad_count, num_checks;
	localparam logic [7:0] mc_tab [7] = '{8'h80, 8'ha0, 8'hc0, 8'he0,
		8'h08, 8'hb0, 8'ha8};
	localparam logic [7:0] ps_tab [7] = '{8'h08, 8'h08, 8'h08, 8'h08,
		8'h10, 8'h08, 8'h08};
	localparam logic [7:0] bd_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h02, 8'h00};
	localparam int bc_tab [7] = '{16, 16, 16, 16, 24, 48, 16};
	localparam int nb_tab [7] = '{9, 9, 9, 9, 7, 9, 8};
	localparam logic [9:0] ex_tab [7] = '{10'h05b, 10'h15b, 10'h15b,
		10'h05b, 10'h05b, 10'h15b, 10'h0db};

	ufbc_core u_dut (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_wb_cyc(req.cyc), .i_wb_stb(req.stb), .i_wb_we(req.we),
		.i_wb_sel(req.sel), .i_wb_adr(req.adr), .i_wb_dat(req.dat),
		.o_wb_dat(rdat), .o_wb_ack(ack),
		.i_rx_pin(rx_line), .o_tx_pin(tx_line),
		.i_serial_clock_pin(1'b0), .o_serial_clock_pin(cko),
		.o_serial_clock_pin_oe_n(ck_oe_n),
		.i_clk_pin_is_output(ck_is_out),
		.o_tx_irq(txi), .o_rx_irq(rxi)
	);
	ufbc_far_end far (
		.i_ref_clk(i_ref_clk), .i_line_in(tx_line), .i_sclk(cko),
		.o_line_out(rx_line)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end

	// ***************************************************************
	// shared tasks
	// ***************************************************************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic give_up();
		bad_count++;
		complete_run();
	endtask
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] a,
		input logic [7:0] d);
		int n;
		@(posedge i_ref_clk);
		req <= '{1'b1, 1'b1, w, 4'h1, a, {24'h000000, d}};
		n = 0;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 64);
		rd = {2'b00, rdat[7:0]};
		req <= '0;
		if (n >= 64) give_up();
	endtask
	task automatic wait_for(input logic sel_rx, input logic v);
		int n;
		n = 0;
		while ((sel_rx ? rxi : cko) !== v && n < 4000) begin
			@(posedge i_ref_clk);
			n++;
		end
		if (n >= 4000) give_up();
	endtask
	task automatic set_rate(input logic [7:0] ps, input logic [7:0] bd);
		wb(1'b1, UFBC_OFF_PSR, 8'h00);
		wb(1'b1, UFBC_OFF_BAUD, bd);
		wb(1'b1, UFBC_OFF_PSR, ps);
	endtask

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_reset();
		wb(1'b0, UFBC_OFF_MAIN, 8'h00);
		check(rd, 10'h001);
		wb(1'b0, UFBC_OFF_PSR, 8'h00);
		check(rd, 10'h000);
		wb(1'b1, 5'h1c, 8'hff);
		wb(1'b0, 5'h1c, 8'h00);
		check(rd, 10'h000);
	endtask
	task automatic t_txirq();
		set_rate(8'h00, 8'h00);
		wb(1'b1, UFBC_OFF_IRQCK, 8'h01);
		repeat (2) @(posedge i_ref_clk);
		check({9'h000, txi}, 10'h001);
		wb(1'b1, UFBC_OFF_TXBUF, 8'h3c);
		repeat (100) @(posedge i_ref_clk);
		check({9'h000, txi}, 10'h000);
		check({9'h000, tx_line}, 10'h001);
		wb(1'b0, UFBC_OFF_MAIN, 8'h00);
		check(rd, 10'h000);
		fork
			far.recv(16, 8, fd, ok);
			wb(1'b1, UFBC_OFF_PSR, 8'h08);
		join
		check(fd, 10'h03c);
		check({9'h000, ok}, 10'h001);
		check({9'h000, txi}, 10'h001);
		wb(1'b1, UFBC_OFF_IRQCK, 8'h00);
		repeat (2) @(posedge i_ref_clk);
		check({9'h000, txi}, 10'h000);
	endtask
	task automatic t_formats();
		for (int i = 0; i < 7; i++) begin
			set_rate(ps_tab[i], bd_tab[i]);
			wb(1'b1, UFBC_OFF_MAIN, mc_tab[i]);
			wb(1'b1, UFBC_OFF_IRQCK, nb_tab[i] == 9 ? 8'h80 : 8'h00);
			fork
				far.recv(bc_tab[i], nb_tab[i], fd, ok);
				wb(1'b1, UFBC_OFF_TXBUF, 8'h5b);
			join
			check(fd, ex_tab[i]);
			check({9'h000, ok}, 10'h001);
			repeat (bc_tab[i]) @(posedge i_ref_clk);
			check({9'h000, tx_line}, 10'h001);
		end
	endtask
	task automatic t_rx(input logic [7:0] mc, input int nb,
		input logic [9:0] d);
		set_rate(8'h08, 8'h00);
		wb(1'b1, UFBC_OFF_MAIN, mc);
		wb(1'b1, UFBC_OFF_IRQCK, 8'h02);
		@(posedge i_ref_clk);
		far.send(16, nb, d);
		wait_for(1'b1, 1'b1);
		check({9'h000, rxi}, 10'h001);
		wb(1'b0, UFBC_OFF_MAIN, 8'h00);
		check(rd & 10'h002, 10'h002);
		wb(1'b0, UFBC_OFF_RXST, 8'h00);
		check(rd & 10'h008, {6'h00, d[8], 3'h0});
		wb(1'b0, UFBC_OFF_RXBUF, 8'h00);
		check(rd, {2'b00, d[7:0]});
		repeat (2) @(posedge i_ref_clk);
		check({9'h000, rxi}, 10'h000);
		wb(1'b0, UFBC_OFF_MAIN, 8'h00);
		check(rd & 10'h002, 10'h000);
	endtask
	task automatic t_sync(input logic [7:0] ps, input logic [7:0] bd,
		input int half);
		int n;
		wb(1'b1, UFBC_OFF_IRQCK, 8'h10);
		set_rate(ps, bd);
		check({9'h000, ck_oe_n}, 10'h000);
		wait_for(1'b0, 1'b0);
		wait_for(1'b0, 1'b1);
		n = 0;
		while (cko === 1'b1 && n < 1000) begin
			@(posedge i_ref_clk);
			n++;
		end
		check(10'(n), 10'(half));
	endtask
	task automatic t_sync_tx();
		wb(1'b1, UFBC_OFF_MAIN, 8'h00);
		fork
			far.recv_sync(8, fd, ok);
			wb(1'b1, UFBC_OFF_TXBUF, 8'h5b);
		join
		check(fd, 10'h05b);
		check({9'h000, ok}, 10'h001);
	endtask

	initial begin
		i_rst = 1'b1;
		req = '0;
		ck_is_out = 1'b1;
		bad_count = 0;
		num_checks = 0;
		repeat (5) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		t_reset();
		t_txirq();
		t_formats();
		t_rx(8'h00, 8, 10'h0a6);
		t_rx(8'h10, 9, 10'h1a6);
		t_sync(8'h09, 8'h00, 257);
		t_sync(8'h18, 8'h02, 6);
		t_sync_tx();
		complete_run();
	end
endmodule
